// ===== include/conv_ctrl_pkg.sv
// Constants shared by the conversion sequencer, its core model, checker and bench.
// Assumes a single 10 MHz clock domain.
package conv_ctrl_pkg;
   localparam int  CLK_PERIOD_NS     = 100;
   localparam int  CONV_MAX_NS       = 1500;   // Longest conversion time
   localparam int  CONV_CYCLES       = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int  REINIT_US         = 200;    // Re-initialization after power-on reset
   localparam int  REINIT_CYCLES     = (REINIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int  RESULT_WIDTH      = 18;
   localparam logic [17:0] RESULT_RESET = 18'h00000;
   typedef enum logic [1:0] {ST_REINIT, ST_NAP, ST_CONVERT} conv_state_t;
endpackage

// ===== core/rise_detect.sv
// Rising-edge detector for a synchronous strobe.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
module rise_detect (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Strobe
   input  wire logic level_in,
   output wire logic rise
);
   logic last_reg;

   // Reset value high so a strobe held high through reset is not a start
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         last_reg <= 1'b1;
      end else begin
         last_reg <= level_in;
      end
   end

   assign rise = level_in & ~last_reg;
endmodule

// ===== core/sar_conversion_control.sv
// Conversion sequencer for an 18-bit successive-approximation converter.
// Assumes convert_strobe is synchronous to clk and that supply_ok comes
// from an external supply monitor (low below 2 V).
//
// What this block does and what it expects of the host
// (RQ1) Strobe rising edge powers up and starts conversion
// (RQ2) Running conversion is never restarted
// (RQ3) Busy stays high for the whole conversion
// (RQ4) Host keeps extra strobe edges early or late
// (RQ5) Core powers down after conversion ends
// (RQ6) Power-on reset at power-up and low supply
// (RQ7) Supply return re-initializes the converter
// (RQ8) Host waits 200 us after power-on reset
// (RQ9) Early conversions are flagged invalid
// (RQ10) Conversion completes within 1.5 us
// (RQ11) Strobe edges while busy are ignored
`timescale 1ns/1ps
module sar_conversion_control
   import conv_ctrl_pkg::*;
#(
   parameter int REINIT_COUNT = REINIT_CYCLES,
   parameter int CONV_COUNT   = CONV_CYCLES
) (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Supply monitor
   input  wire logic                    supply_ok,
   // Host conversion control
   input  wire logic                    convert_strobe,
   output wire logic                    busy,
   // Analog core control
   output wire logic                    core_power,
   output wire logic                    core_sample,
   input  wire logic [RESULT_WIDTH-1:0] core_result,
   // Conversion result and re-initialization status
   output logic      [RESULT_WIDTH-1:0] result,
   output logic                         result_valid,
   output logic                         result_strobe,
   output wire logic                    reinit_active
);
   localparam int CW = $clog2(REINIT_COUNT + CONV_COUNT + 1);

   // Counts below one would leave the end-of-phase compare unreachable
   if (CONV_COUNT < 1 || REINIT_COUNT < 1) begin : g_bad_count
      $error("sar_conversion_control: counts must be at least one");
   end

   // Converting decode is shared by busy, core power and the start gate
   function automatic logic is_converting(input conv_state_t st);
      is_converting = (st == ST_CONVERT);
   endfunction

   conv_state_t    state_reg;
   conv_state_t    state_next;
   logic [CW-1:0]  count_reg;
   logic [CW-1:0]  count_next;
   logic           early_reg;
   logic           early_next;
   logic           por_done_reg;

   wire            strobe_rise;
   wire            start;
   wire            conv_end;
   wire            reinit_end;

   rise_detect edge_u (
      .clk      (clk),
      .rst_n    (rst_n),
      .level_in (convert_strobe),
      .rise     (strobe_rise)
   );

   // Edges in convert state are masked here and never reach the case as a start
   assign start      = strobe_rise && !is_converting(state_reg);           // RQ2
   assign conv_end   = (state_reg == ST_CONVERT) && (count_reg == CW'(CONV_COUNT - 1)); // RQ10
   assign reinit_end = (state_reg == ST_REINIT) && (count_reg == CW'(REINIT_COUNT - 1));

   assign busy          = is_converting(state_reg);                        // RQ3
   assign core_power    = is_converting(state_reg);                        // RQ5
   assign core_sample   = start;                                           // RQ1
   assign reinit_active = (state_reg == ST_REINIT);

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      early_next = early_reg;
      case (state_reg)
         ST_REINIT: begin
            count_next = count_reg + CW'(1);
            if (start) begin
               // A start during re-initialization still runs, marked bad
               state_next = ST_CONVERT;                                    // RQ9
               count_next = '0;
               early_next = 1'b1;
            end else if (reinit_end) begin
               state_next = ST_NAP;
               count_next = '0;
            end
         end
         ST_NAP: begin
            if (start) begin
               state_next = ST_CONVERT;                                    // RQ1
               count_next = '0;
               early_next = 1'b0;
            end
         end
         ST_CONVERT: begin
            count_next = count_reg + CW'(1);                               // RQ11
            if (conv_end) begin
               // An aborted re-initialization restarts after the conversion
               state_next = early_reg ? ST_REINIT : ST_NAP;                // RQ5
               count_next = '0;
            end
         end
         default: begin
            state_next = ST_REINIT;
            count_next = '0;
         end
      endcase
      // Supply drop forces re-initialization, overriding all else
      if (!supply_ok) begin                                                // RQ6
         state_next = ST_REINIT;
         count_next = '0;
         early_next = 1'b0;
      end
   end

   // Power-on reset is modelled by rst_n plus the supply monitor
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg    <= ST_REINIT;                                        // RQ6
         count_reg    <= '0;
         early_reg    <= 1'b0;
         por_done_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;                                       // RQ7
         count_reg    <= count_next;
         early_reg    <= early_next;
         por_done_reg <= supply_ok && (por_done_reg || reinit_end);
      end
   end

   // Result registered at end of conversion; valid only after full init
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result        <= RESULT_RESET;
         result_valid  <= 1'b0;
         result_strobe <= 1'b0;
      end else begin
         result_strobe <= conv_end && supply_ok;
         if (!supply_ok) begin
            result_valid <= 1'b0;
         end else if (conv_end) begin
            result       <= core_result;
            result_valid <= ~early_reg && por_done_reg;                    // RQ9
         end
      end
   end
endmodule

// ===== tb/core_model.sv
// Analog core stand-in facing the sequencer.
// Assumes the bench sets the level to be converted.
`timescale 1ns/1ps
module core_model
   import conv_ctrl_pkg::*;
(
   input  wire logic                    power,
   input  wire logic [RESULT_WIDTH-1:0] level,
   output wire logic [RESULT_WIDTH-1:0] code
);
   // Unpowered core shows the inverse so a stale read cannot pass
   assign code = power ? level : ~level;
endmodule

// ===== tb/sar_cc_asserts.sv
// Port checker for the conversion sequencer.
// Assumes one clock domain; bound below.
`timescale 1ns/1ps
module sar_cc_asserts
   import conv_ctrl_pkg::*;
#(parameter int REINIT_COUNT = 20, parameter int CONV_COUNT = 4) (
   input wire logic clk, rst_n, supply_ok, convert_strobe, busy, core_power,
   input wire logic core_sample, result_valid, result_strobe, reinit_active,
   input wire logic [RESULT_WIDTH-1:0] core_result, result
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] run_reg;
   logic       early_reg;
   always_ff @(posedge clk) begin
      run_reg <= busy ? run_reg + 8'h01 : 8'h00;
      early_reg <= !rst_n ? 1'b0 : core_sample ? reinit_active : early_reg;
   end
   sequence s_done;
      result_strobe && result == $past(core_result) ##1 !result_strobe;
   endsequence
   chk_start_busy: assert property (core_sample && supply_ok |=> busy)
      else $error("start lost");
   chk_power_busy: assert property (core_power == busy)
      else $error("core power wrong");
   chk_no_restart: assert property (core_sample |-> !busy)
      else $error("restart while busy");
   chk_busy_len: assert property (
      $fell(busy) && $past(supply_ok) |-> run_reg == CONV_COUNT) else $error("busy length");
   chk_result_out: assert property ($fell(busy) && $past(supply_ok) |-> s_done)
      else $error("result not stored");
   chk_supply_drop: assert property (
      !supply_ok |=> reinit_active && !busy && !result_valid) else $error("no reset on drop");
   chk_supply_back: assert property ($rose(supply_ok) |-> reinit_active[*8])
      else $error("no reinit");
   chk_early_flag: assert property (result_strobe |-> result_valid == !early_reg)
      else $error("valid flag wrong");
   chk_power_on: assert property ($rose(rst_n) |-> reinit_active && !busy)
      else $error("no reinit at start");
endmodule
bind sar_conversion_control sar_cc_asserts
   #(.REINIT_COUNT(REINIT_COUNT), .CONV_COUNT(CONV_COUNT)) u_chk (.*);

// ===== tb/tb_top.sv
// Bench for the conversion sequencer with short counts.
// Assumes the core model as far side.
`timescale 1ns/1ps
module tb_top;
   import conv_ctrl_pkg::*;
   logic clk = 0, rst_n = 0, supply_ok = 1, convert_strobe = 0;
   logic busy, core_power, core_sample, result_valid, result_strobe, reinit_active;
   logic [RESULT_WIDTH-1:0] core_result, result, level = 18'h2a5c3;
   int error_cnt = 0, n_compared = 0;
   sar_conversion_control #(.REINIT_COUNT(20), .CONV_COUNT(4)) u_sar_conversion_control (.*);
   core_model u_core_model (.power(core_power), .level(level), .code(core_result));
   initial forever #50 clk = ~clk;
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (reinit_active !== 1'b0) begin
         @(negedge clk);
         n++;
         if (n > 100) begin
            error_cnt++;
            results;
         end
      end
   endtask
   // Poke toggles the strobe while busy, on purpose outside the early window
   task automatic conv(bit poke, logic exp_valid);
      int n;
      n = 0;
      @(negedge clk) convert_strobe = 1;
      @(negedge clk) check(busy, 1);
      while (busy === 1'b1 && n < 50) begin
         convert_strobe = poke ? n[0] : 1'b1;
         n++;
         @(negedge clk);
      end
      convert_strobe = 0;
      check(n, 4);
      check(result_strobe, 1);
      check(result, level);
      check(result_valid, exp_valid);
      check(core_power, 0);
      level = {level[16:0], ~level[17]};
      @(negedge clk) check(result_strobe, 0);
   endtask
   task automatic supply_drop;
      @(negedge clk) convert_strobe = 1;
      @(negedge clk) supply_ok = 0;
      @(negedge clk) check(busy, 0);
      check(result_valid, 0);
      convert_strobe = 0;
      supply_ok = 1;
      repeat (2) @(negedge clk);
      check(reinit_active, 1);
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1;
      check(reinit_active, 1);
      conv(0, 0);
      wait_ready;
      conv(1, 1);
      conv(0, 1);
      supply_drop;
      wait_ready;
      conv(0, 1);
      results;
   end
endmodule
